//--- common/sgl_pkg.sv
// constants shared by both ends of the pin link
package sgl_pkg;
	localparam int NPIN = 4;
	localparam int BC_BITS = 30;
	localparam int FC_BITS = 40;
	// device register offsets
	localparam logic [7:0] REG_LOCAL_DATA = 8'h0d;
	localparam logic [7:0] REG_PIN_DIR = 8'h0e;
	localparam logic [7:0] REG_FWD_CFG = 8'h33;
	localparam logic [7:0] REG_PIN_STS = 8'h53;
	localparam logic [7:0] REG_SENSE_CTL = 8'h20;
	localparam logic [7:0] REG_SENSE_STS = 8'h21;
	localparam logic [7:0] PIN_DIR_RST = 8'h0f;
	localparam logic [7:0] LOCAL_DATA_RST = 8'h00;
	localparam logic [2:0] FWD_CNT_RST = 3'h0;
	localparam logic [1:0] SENSE_RST = 2'h0;
	localparam int DIR_OE_LSB = 4;
	localparam int LD_REM_LSB = 4;
	// back frame fields
	localparam int BC_CMD_V = 29;
	localparam int BC_CMD_W = 28;
	localparam int BC_ADDR_LSB = 20;
	localparam int BC_WDATA_LSB = 12;
	localparam int BC_PIN_LSB = 8;
	// forward frame fields
	localparam int FC_RSP_V = 39;
	localparam int FC_RDATA_LSB = 31;
	localparam int FC_PIN_LSB = 27;
	// forward sampling periods in frames
	localparam logic [2:0] FWD_PER_1 = 3'h1;
	localparam logic [2:0] FWD_PER_2 = 3'h2;
	localparam logic [2:0] FWD_PER_34 = 3'h5;
	// controller registers (byte addresses)
	localparam logic [7:0] HR_CMD = 8'h00;
	localparam logic [7:0] HR_STS = 8'h04;
	localparam logic [7:0] HR_BCPIN = 8'h08;
	localparam logic [7:0] HR_FWDPIN = 8'h0c;
	localparam logic [7:0] HR_FS_CTL = 8'h10;
	localparam logic [7:0] HR_MODE = 8'h14;
	localparam int CMD_WR_BIT = 16;
	localparam int CMD_ADDR_LSB = 8;
	localparam int FS_INT_BIT = 0;
	localparam int FS_EXT_BIT = 1;
	localparam int FS_SLOT_LSB = 2;
	localparam int FS_PER_LSB = 16;
	localparam logic [15:0] FS_PER_RST = 16'h0010;
	// link clock periods; ratio 50 : 10 : 2.5 Mbps
	localparam int CLK_NS = 100;
	localparam int LPER_SYNC_NS = 800;
	localparam int LPER_NSYNC_NS = 4000;
	localparam int LPER_PAR_NS = 16000;
	localparam logic [7:0] LHALF_SYNC = 8'(LPER_SYNC_NS / CLK_NS / 2);
	localparam logic [7:0] LHALF_NSYNC = 8'(LPER_NSYNC_NS / CLK_NS / 2);
	localparam logic [7:0] LHALF_PAR = 8'(LPER_PAR_NS / CLK_NS / 2);
	typedef enum logic [1:0] {
		RATE_SYNC = 2'b00,
		RATE_NSYNC = 2'b01,
		RATE_PAR = 2'b10
	} sgl_rate_e;
	typedef enum logic [1:0] {
		CMD_IDLE = 2'b00,
		CMD_SEND = 2'b01,
		CMD_WAIT = 2'b10
	} sgl_cmd_e;
endpackage

//--- common/sgl_link_if.sv
// link between serializer end and deserializer end
`timescale 1ns/1ps
interface sgl_link_if;
	logic link_clk;
	logic bc_sync;
	logic bc_data;
	logic fc_sync;
	logic fc_data;
	modport ser_mp(input link_clk, bc_sync, bc_data,
		output fc_sync, fc_data);
	modport des_mp(output link_clk, bc_sync, bc_data,
		input fc_sync, fc_data);
endinterface

//--- verilog/sgl_sync2.sv
// two flip-flop synchroniser
`timescale 1ns/1ps
module sgl_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// async in, synced out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sgl_sy_s;
	sgl_sy_s r_ff, nxt_r;
	always_comb begin
		nxt_r.s1 = d;
		nxt_r.s2 = r_ff.s1;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end
	assign q = r_ff.s2;
endmodule // sgl_sync2

//--- verilog/sgl_ser_end.sv
// serializer end: pin unit, its registers and link framing
//
// Implementation choice: link command frames as the only access to the registers.
`timescale 1ns/1ps
module sgl_ser_end
	import sgl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link
	sgl_link_if.ser_mp link,
	// pins
	input wire logic [NPIN-1:0] pin_in,
	output logic [NPIN-1:0] pin_out,
	output logic [NPIN-1:0] pin_oe,
	output logic [NPIN-1:0] pin_pd,
	// voltage sense codes of pins 0 and 1
	input wire logic [2:0] sense_code0,
	input wire logic [2:0] sense_code1
);
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] ldata;
		logic [2:0] fcnt;
		logic [1:0] sense;
		logic lclk_d;
		logic [BC_BITS-1:0] bc_sr;
		logic [4:0] bc_cnt;
		logic [NPIN-1:0] bc_pin;
		logic rsp_pend;
		logic [7:0] rsp_data;
		logic [FC_BITS-1:0] fc_sr;
		logic [5:0] fc_cnt;
		logic fc_sync;
		logic fc_bit;
		logic [2:0] fwd_div;
		logic [NPIN-1:0] fwd_hold;
		logic [NPIN-1:0] pin_out;
	} sgl_ser_s;

	sgl_ser_s r_ff, nxt_r;
	logic [2:0] lnk_s;
	logic [NPIN-1:0] pin_s;
	logic [5:0] sns_s;

	sgl_sync2 #(.W(3)) u_lnk_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({link.link_clk, link.bc_sync, link.bc_data}),
		.q(lnk_s)
	);
	sgl_sync2 #(.W(NPIN + 6)) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({pin_in, sense_code1, sense_code0}),
		.q({pin_s, sns_s})
	);

	logic rise, fall;
	logic [NPIN-1:0] ie, smask, fmask, lvl;
	logic [2:0] per;
	logic [7:0] sts;
	logic [BC_BITS-1:0] bframe;
	logic [FC_BITS-1:0] fframe;
	logic [7:0] addr, wdat, rd;

	always_comb begin
		nxt_r = r_ff;
		rise = lnk_s[2] & ~r_ff.lclk_d;
		fall = ~lnk_s[2] & r_ff.lclk_d;
		nxt_r.lclk_d = lnk_s[2];
		ie = r_ff.dir[NPIN-1:0];
		// sensed pins give no logic level
		smask = {2'b00, r_ff.sense};
		lvl = pin_s & ~smask;
		sts = {4'h0, lvl & ie};
		// linked count sets mask and period
		case (r_ff.fcnt)
			3'h0: begin
				fmask = 4'h0;
				per = FWD_PER_1;
			end
			3'h1: begin
				fmask = 4'h1;
				per = FWD_PER_1;
			end
			3'h2: begin
				fmask = 4'h3;
				per = FWD_PER_2;
			end
			3'h3: begin
				fmask = 4'h7;
				per = FWD_PER_34;
			end
			default: begin
				fmask = 4'hf;
				per = FWD_PER_34;
			end
		endcase
		bframe = {r_ff.bc_sr[BC_BITS-2:0], lnk_s[0]};
		addr = bframe[BC_ADDR_LSB +: 8];
		wdat = bframe[BC_WDATA_LSB +: 8];
		case (addr)
			REG_LOCAL_DATA: rd = r_ff.ldata;
			REG_PIN_DIR: rd = r_ff.dir;
			REG_FWD_CFG: rd = {5'h00, r_ff.fcnt};
			REG_PIN_STS: rd = sts;
			REG_SENSE_CTL: rd = {6'h00, r_ff.sense};
			REG_SENSE_STS: rd = {2'b00, sns_s};
			default: rd = 8'h00;
		endcase
		fframe = '0;
		// back frame reception on link rise
		if (rise) begin
			if (lnk_s[1]) begin
				nxt_r.bc_sr = {{(BC_BITS-1){1'b0}}, lnk_s[0]};
				nxt_r.bc_cnt = 5'h01;
			end else if (r_ff.bc_cnt != 5'h00) begin
				nxt_r.bc_sr = bframe;
				nxt_r.bc_cnt = r_ff.bc_cnt + 5'h01;
				if (r_ff.bc_cnt == 5'(BC_BITS - 1)) begin
					nxt_r.bc_cnt = 5'h00;
					nxt_r.bc_pin = bframe[BC_PIN_LSB +: NPIN];
					if (bframe[BC_CMD_V]) begin
						nxt_r.rsp_pend = 1'b1;
						nxt_r.rsp_data = rd;
						if (bframe[BC_CMD_W]) begin
							nxt_r.rsp_data = wdat;
							case (addr)
								REG_LOCAL_DATA: nxt_r.ldata = wdat;
								REG_PIN_DIR: nxt_r.dir = wdat;
								REG_FWD_CFG: nxt_r.fcnt = wdat[2:0];
								REG_SENSE_CTL: nxt_r.sense = wdat[1:0];
								default: nxt_r.fcnt = r_ff.fcnt;
							endcase
						end
					end
				end
			end
		end
		// forward frame transmission on link fall
		if (fall) begin
			if (r_ff.fc_cnt == 6'h00) begin
				if (r_ff.fwd_div == 3'h0) begin
					nxt_r.fwd_hold = lvl & ie & fmask;
				end
				if (r_ff.fwd_div + 3'h1 >= per) begin
					nxt_r.fwd_div = 3'h0;
				end else begin
					nxt_r.fwd_div = r_ff.fwd_div + 3'h1;
				end
				fframe[FC_RSP_V] = r_ff.rsp_pend;
				fframe[FC_RDATA_LSB +: 8] = r_ff.rsp_data;
				fframe[FC_PIN_LSB +: NPIN] = nxt_r.fwd_hold;
				nxt_r.rsp_pend = 1'b0;
				nxt_r.fc_sync = 1'b1;
				nxt_r.fc_bit = fframe[FC_BITS-1];
				nxt_r.fc_sr = {fframe[FC_BITS-2:0], 1'b0};
				nxt_r.fc_cnt = 6'h01;
			end else begin
				nxt_r.fc_sync = 1'b0;
				nxt_r.fc_bit = r_ff.fc_sr[FC_BITS-1];
				nxt_r.fc_sr = {r_ff.fc_sr[FC_BITS-2:0], 1'b0};
				if (r_ff.fc_cnt == 6'(FC_BITS - 1)) begin
					nxt_r.fc_cnt = 6'h00;
				end else begin
					nxt_r.fc_cnt = r_ff.fc_cnt + 6'h01;
				end
			end
		end
		for (int i = 0; i < NPIN; i++) begin
			nxt_r.pin_out[i] = nxt_r.ldata[LD_REM_LSB + i] ?
				nxt_r.bc_pin[i] : nxt_r.ldata[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_ff <= '0;
			r_ff.dir <= PIN_DIR_RST;
			r_ff.ldata <= LOCAL_DATA_RST;
			r_ff.fcnt <= FWD_CNT_RST;
			r_ff.sense <= SENSE_RST;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign pin_out = r_ff.pin_out;
	assign pin_oe = r_ff.dir[DIR_OE_LSB +: NPIN];
	assign pin_pd = r_ff.dir[NPIN-1:0];
	assign link.fc_sync = r_ff.fc_sync;
	assign link.fc_data = r_ff.fc_bit;
endmodule // sgl_ser_end

//--- verilog/sgl_des_end.sv
// deserializer end: link clock, command relay, frame sync
`timescale 1ns/1ps
module sgl_des_end
	import sgl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// link
	sgl_link_if.des_mp link,
	// user side
	input wire logic ext_frame_sync,
	output logic [NPIN-1:0] fwd_pin_out
);
	typedef struct packed {
		logic [7:0] div;
		logic lclk;
		logic [BC_BITS-1:0] bc_sr;
		logic [4:0] bc_cnt;
		logic bc_sync;
		logic bc_bit;
		logic [FC_BITS-1:0] fc_sr;
		logic [5:0] fc_cnt;
		logic [NPIN-1:0] fwd;
		sgl_cmd_e st;
		logic [16:0] cmd;
		logic [7:0] rdata;
		logic done;
		logic [NPIN-1:0] bcpin;
		logic [31:0] fs_ctl;
		logic [15:0] fs_cnt;
		sgl_rate_e mode;
		logic a_act;
		logic a_wr;
		logic [7:0] a_addr;
		logic [31:0] hrdata;
	} sgl_des_s;

	sgl_des_s r_ff, nxt_r;
	logic [2:0] in_s;

	sgl_sync2 #(.W(3)) u_in_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({link.fc_sync, link.fc_data, ext_frame_sync}),
		.q(in_s)
	);

	logic [7:0] half;
	logic [31:0] rd;
	logic [BC_BITS-1:0] bf;
	logic [FC_BITS-1:0] ff;
	logic [NPIN-1:0] pins;
	logic fs_lvl;

	always_comb begin
		nxt_r = r_ff;
		case (r_ff.mode)
			RATE_SYNC: half = LHALF_SYNC;
			RATE_NSYNC: half = LHALF_NSYNC;
			default: half = LHALF_PAR;
		endcase
		// read mux on the word address of the address phase
		case ({haddr[7:2], 2'b00})
			HR_CMD: rd = {15'h0000, r_ff.cmd};
			HR_STS: rd = {16'h0000, r_ff.rdata, 6'h00, r_ff.done,
				r_ff.st != CMD_IDLE};
			HR_BCPIN: rd = {28'h0000000, r_ff.bcpin};
			HR_FWDPIN: rd = {28'h0000000, r_ff.fwd};
			HR_FS_CTL: rd = r_ff.fs_ctl;
			HR_MODE: rd = {30'h00000000, r_ff.mode};
			default: rd = 32'h00000000;
		endcase
		// internal pulse or relayed external level
		fs_lvl = r_ff.fs_ctl[FS_INT_BIT] ? (r_ff.fs_cnt == 16'h0000) :
			(r_ff.fs_ctl[FS_EXT_BIT] & in_s[0]);
		pins = r_ff.bcpin;
		if (r_ff.fs_ctl[FS_INT_BIT] | r_ff.fs_ctl[FS_EXT_BIT]) begin
			pins[r_ff.fs_ctl[FS_SLOT_LSB +: 2]] = fs_lvl;
		end
		bf = '0;
		ff = {r_ff.fc_sr[FC_BITS-2:0], in_s[1]};
		if (r_ff.div == 8'h00) begin
			nxt_r.div = half - 8'h01;
			nxt_r.lclk = ~r_ff.lclk;
			if (r_ff.lclk) begin
				// back frame sent on falling link clock
				if (r_ff.bc_cnt == 5'h00) begin
					bf[BC_CMD_V] = r_ff.st == CMD_SEND;
					bf[BC_CMD_W] = r_ff.cmd[CMD_WR_BIT];
					bf[BC_ADDR_LSB +: 8] = r_ff.cmd[CMD_ADDR_LSB +: 8];
					bf[BC_WDATA_LSB +: 8] = r_ff.cmd[7:0];
					bf[BC_PIN_LSB +: NPIN] = pins;
					if (r_ff.st == CMD_SEND) begin
						nxt_r.st = CMD_WAIT;
					end
					if (r_ff.fs_cnt + 16'h0001 >= r_ff.fs_ctl[FS_PER_LSB +: 16]) begin
						nxt_r.fs_cnt = 16'h0000;
					end else begin
						nxt_r.fs_cnt = r_ff.fs_cnt + 16'h0001;
					end
					nxt_r.bc_sync = 1'b1;
					nxt_r.bc_bit = bf[BC_BITS-1];
					nxt_r.bc_sr = {bf[BC_BITS-2:0], 1'b0};
					nxt_r.bc_cnt = 5'h01;
				end else begin
					nxt_r.bc_sync = 1'b0;
					nxt_r.bc_bit = r_ff.bc_sr[BC_BITS-1];
					nxt_r.bc_sr = {r_ff.bc_sr[BC_BITS-2:0], 1'b0};
					nxt_r.bc_cnt = (r_ff.bc_cnt == 5'(BC_BITS - 1)) ?
						5'h00 : r_ff.bc_cnt + 5'h01;
				end
				// forward frame sampled on falling link clock
				if (in_s[2]) begin
					nxt_r.fc_sr = {{(FC_BITS-1){1'b0}}, in_s[1]};
					nxt_r.fc_cnt = 6'h01;
				end else if (r_ff.fc_cnt != 6'h00) begin
					nxt_r.fc_sr = ff;
					nxt_r.fc_cnt = r_ff.fc_cnt + 6'h01;
					if (r_ff.fc_cnt == 6'(FC_BITS - 1)) begin
						nxt_r.fc_cnt = 6'h00;
						nxt_r.fwd = ff[FC_PIN_LSB +: NPIN];
						if (ff[FC_RSP_V] && r_ff.st == CMD_WAIT) begin
							nxt_r.rdata = ff[FC_RDATA_LSB +: 8];
							nxt_r.done = 1'b1;
							nxt_r.st = CMD_IDLE;
						end
					end
				end
			end
		end else begin
			nxt_r.div = r_ff.div - 8'h01;
		end
		// ahb data phase write
		if (r_ff.a_act && r_ff.a_wr) begin
			case (r_ff.a_addr)
				HR_CMD: begin
					if (r_ff.st == CMD_IDLE) begin
						nxt_r.cmd = hwdata[16:0];
						nxt_r.st = CMD_SEND;
						nxt_r.done = 1'b0;
					end
				end
				HR_BCPIN: nxt_r.bcpin = hwdata[NPIN-1:0];
				HR_FS_CTL: nxt_r.fs_ctl = hwdata;
				HR_MODE: nxt_r.mode = sgl_rate_e'(hwdata[1:0]);
				default: nxt_r.a_wr = 1'b0;
			endcase
		end
		// ahb address phase; read data loaded here
		nxt_r.a_act = hsel & htrans[1] & hready;
		if (hready) begin
			nxt_r.a_wr = hwrite;
			nxt_r.a_addr = {haddr[7:2], 2'b00};
		end
		if (hsel && htrans[1] && hready && !hwrite) begin
			nxt_r.hrdata = rd;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_ff <= '0;
			r_ff.st <= CMD_IDLE;
			r_ff.mode <= RATE_SYNC;
			r_ff.fs_ctl <= {FS_PER_RST, 16'h0000};
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r_ff.hrdata;
	assign link.link_clk = r_ff.lclk;
	assign link.bc_sync = r_ff.bc_sync;
	assign link.bc_data = r_ff.bc_bit;
	assign fwd_pin_out = r_ff.fwd;
endmodule // sgl_des_end

//--- tb/sgl_link_monitor.sv
// wire checks on the link between the two ends
`timescale 1ns/1ps
module sgl_link_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link wires
	input wire logic link_clk,
	input wire logic bc_sync,
	input wire logic bc_data,
	input wire logic fc_sync,
	input wire logic fc_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] bn_ff, fn_ff, idle_ff;
	logic bok_ff, fok_ff, bp_ff, fp_ff;
	// bit position since frame start, per sampling edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bn_ff <= '0;
			fn_ff <= '0;
			idle_ff <= '0;
			bok_ff <= 1'b0;
			fok_ff <= 1'b0;
			bp_ff <= 1'b0;
			fp_ff <= 1'b0;
		end else begin
			idle_ff <= $changed(link_clk) ? 8'h00 : idle_ff + 8'h01;
			if ($rose(bc_sync)) begin
				bn_ff <= '0;
				bok_ff <= 1'b1;
			end else if ($rose(link_clk)) begin
				bn_ff <= bn_ff + 8'h01;
			end
			if ($rose(fc_sync)) begin
				fn_ff <= '0;
				fok_ff <= 1'b1;
			end else if ($fell(link_clk)) begin
				fn_ff <= fn_ff + 8'h01;
			end
			if ($rose(link_clk))
				bp_ff <= bc_sync;
			if ($fell(link_clk))
				fp_ff <= fc_sync;
		end
	end
	bc_frame_len_a: assert property (
		$rose(bc_sync) && bok_ff |-> bn_ff == 8'h1e)
		else $error("back frame is not 30 bits");
	fc_frame_len_a: assert property (
		$rose(fc_sync) && fok_ff |-> fn_ff == 8'h28)
		else $error("forward frame is not 40 bits");
	bc_sync_single_a: assert property (
		$rose(link_clk) && bc_sync |-> !bp_ff)
		else $error("back sync longer than one bit");
	fc_sync_single_a: assert property (
		$fell(link_clk) && fc_sync |-> !fp_ff)
		else $error("forward sync longer than one bit");
	bc_tail_zero_a: assert property (
		$rose(link_clk) && bok_ff && bn_ff >= 8'h16 |-> !bc_data)
		else $error("back frame tail not zero");
	fc_tail_zero_a: assert property (
		$fell(link_clk) && fok_ff && fn_ff >= 8'h0d |-> !fc_data)
		else $error("forward frame tail not zero");
	bc_launch_edge_a: assert property (
		$changed(bc_data) || $changed(bc_sync) |-> !link_clk)
		else $error("back bit changed outside link fall");
	fc_hold_edge_a: assert property (
		$fell(link_clk) |-> $stable(fc_data) && $stable(fc_sync))
		else $error("forward bit moved at sampling edge");
	link_half_min_a: assert property (
		$changed(link_clk) |=> $stable(link_clk)[*3])
		else $error("link clock half period too short");
	link_alive_a: assert property (
		idle_ff <= 8'ha0)
		else $error("link clock stopped");
endmodule // sgl_link_monitor

//--- tb/testbench.sv
// both link ends joined, driven over the bus and the pads
`timescale 1ns/1ps
module testbench;
	import sgl_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic hreadyout, hresp;
	logic [31:0] hrdata;
	logic ext_frame_sync = 1'b0;
	logic [3:0] pad = '0;
	logic [2:0] sns0 = 3'h3;
	logic [2:0] sns1 = 3'h5;
	logic [3:0] pin_in, pin_out, pin_oe, pin_pd, fwd_pin_out;
	logic [3:0] pv [4] = '{4'hf, 4'h2, 4'h5, 4'ha};
	logic [7:0] hv [3] = '{LHALF_SYNC, LHALF_NSYNC, LHALF_PAR};
	int error_cnt = 0;
	int n_tests = 0;
	sgl_link_if lnk();
	always #50 clk = ~clk;
	// a pad that the end drives reads back its own level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & pad);
	sgl_ser_end u_sgl_ser_end (.clk(clk), .rst_n(rst_n), .link(lnk),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pd(pin_pd), .sense_code0(sns0), .sense_code1(sns1));
	sgl_des_end u_sgl_des_end (.clk(clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .link(lnk),
		.ext_frame_sync(ext_frame_sync), .fwd_pin_out(fwd_pin_out));
	sgl_link_monitor u_sgl_link_monitor (.clk(clk), .rst_n(rst_n),
		.link_clk(lnk.link_clk), .bc_sync(lnk.bc_sync),
		.bc_data(lnk.bc_data), .fc_sync(lnk.fc_sync),
		.fc_data(lnk.fc_data));
	task final_report();
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task hang(input string what);
		error_cnt++;
		$display("MISMATCH %s expected done seen timeout", what);
		final_report();
	endtask
	task wrdy();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50)
			hang("bus ready");
	endtask
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hsize <= 3'h2;
		wrdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wrdy();
		rd = hrdata;
		chk("hresp", 32'h0, hresp);
	endtask
	task dev(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] rd);
		logic [31:0] r;
		int n;
		ahb(1'b1, HR_CMD, {15'h0, wr, a, d}, r);
		n = 0;
		do begin
			ahb(1'b0, HR_STS, '0, r);
			n++;
		end while (r[0] !== 1'b1 && n < 20);
		if (r[0] !== 1'b1)
			hang("command start");
		do begin
			ahb(1'b0, HR_STS, '0, r);
			n++;
		end while ((r[0] !== 1'b0 || r[1] !== 1'b1) && n < 3000);
		if (r[0] !== 1'b0 || r[1] !== 1'b1)
			hang("device command");
		rd = r[15:8];
	endtask
	task wait_pins(input logic [3:0] m, input logic [3:0] v, input int lim,
		input logic fwd);
		int n;
		n = 0;
		while (((fwd ? fwd_pin_out : pin_out) & m) !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (((fwd ? fwd_pin_out : pin_out) & m) !== v)
			hang("pin level");
	endtask
	task lrise(output int n);
		logic p;
		logic hit;
		n = 0;
		p = 1'b1;
		hit = 1'b0;
		while (n < 400 && !hit) begin
			@(posedge clk);
			n++;
			hit = !p && lnk.link_clk === 1'b1;
			p = lnk.link_clk;
		end
		if (!hit)
			hang("link clock rise");
	endtask
	task t_reset();
		logic [7:0] r;
		chk("pin_oe", 4'h0, pin_oe);
		chk("pin_pd", 4'hf, pin_pd);
		dev(1'b0, REG_PIN_DIR, 8'h00, r);
		chk("direction", 8'h0f, r);
		pad <= 4'ha;
		dev(1'b0, REG_PIN_STS, 8'h00, r);
		chk("status", 4'ha, r & 8'h0f);
	endtask
	task t_dir();
		logic [7:0] r;
		dev(1'b1, REG_PIN_DIR, 8'h3c, r);
		chk("pin_oe", 4'h3, pin_oe);
		chk("pin_pd", 4'hc, pin_pd);
		dev(1'b1, REG_LOCAL_DATA, 8'h02, r);
		chk("pin_out", 4'h2, pin_out & 4'h3);
		dev(1'b0, REG_PIN_STS, 8'h00, r);
		chk("status", pad & 4'hc, r & 8'h0f);
		dev(1'b1, REG_PIN_DIR, 8'hff, r);
		dev(1'b1, REG_LOCAL_DATA, 8'h05, r);
		chk("pin_pd", 4'hf, pin_pd);
		dev(1'b0, REG_PIN_STS, 8'h00, r);
		chk("status", 4'h5, r & 8'h0f);
		dev(1'b1, REG_PIN_STS, 8'hff, r);
		dev(1'b0, REG_PIN_STS, 8'h00, r);
		chk("status", 4'h5, r & 8'h0f);
	endtask
	task t_fwd();
		logic [7:0] r;
		logic [3:0] m;
		logic [31:0] w;
		dev(1'b1, REG_PIN_DIR, 8'h0f, r);
		for (int c = 1; c <= 4; c++) begin
			// pad held until the forwarded pins match, at most 4000 clocks
			pad <= pv[c-1];
			dev(1'b1, REG_FWD_CFG, 8'(c), r);
			m = 4'((1 << c) - 1);
			wait_pins(m, pv[c-1] & m, 4000, 1'b1);
			chk("fwd", pv[c-1] & m, fwd_pin_out & m);
			ahb(1'b0, HR_FWDPIN, '0, w);
			chk("fwd register", pv[c-1] & m, w);
		end
	endtask
	task t_sense();
		logic [7:0] r;
		pad <= 4'hf;
		dev(1'b1, REG_SENSE_CTL, 8'h03, r);
		dev(1'b0, REG_SENSE_STS, 8'h00, r);
		chk("sense codes", {2'b00, sns1, sns0}, r);
		dev(1'b0, REG_PIN_STS, 8'h00, r);
		chk("sensed status", 4'hc, r & 8'h0f);
		dev(1'b1, REG_SENSE_CTL, 8'h00, r);
		dev(1'b0, REG_PIN_STS, 8'h00, r);
		chk("status", 4'hf, r & 8'h0f);
	endtask
	task t_back();
		logic [7:0] r;
		logic [31:0] w;
		dev(1'b1, REG_PIN_DIR, 8'hf0, r);
		dev(1'b1, REG_LOCAL_DATA, 8'hf0, r);
		chk("pin_pd", 4'h0, pin_pd);
		for (int i = 0; i < 2; i++) begin
			ahb(1'b1, HR_BCPIN, i ? 32'h6 : 32'h9, w);
			wait_pins(4'hf, i ? 4'h6 : 4'h9, 2000, 1'b0);
			chk("pin_out", i ? 4'h6 : 4'h9, pin_out);
		end
	endtask
	task t_fs();
		logic [31:0] w;
		ahb(1'b1, HR_BCPIN, '0, w);
		for (int s = 0; s < 4; s++) begin
			ahb(1'b1, HR_FS_CTL, (1 << FS_EXT_BIT) | (s << FS_SLOT_LSB), w);
			wait_pins(4'hf, 4'h0, 1000, 1'b0);
			ext_frame_sync <= 1'b1;
			wait_pins(4'(1 << s), 4'(1 << s), 600, 1'b0);
			chk("relayed sync", 1'b1, pin_out[s]);
			ext_frame_sync <= 1'b0;
		end
		ahb(1'b1, HR_FS_CTL, 32'(FS_PER_RST) << FS_PER_LSB | 32'h1, w);
		wait_pins(4'h1, 4'h1, 6000, 1'b0);
		chk("internal sync", 1'b1, pin_out[0]);
		wait_pins(4'h1, 4'h0, 600, 1'b0);
		chk("internal sync end", 1'b0, pin_out[0]);
	endtask
	task t_mode();
		logic [31:0] w;
		int n;
		for (int m = 0; m < 3; m++) begin
			ahb(1'b1, HR_MODE, 32'(m), w);
			lrise(n);
			lrise(n);
			lrise(n);
			chk("link period", 2 * hv[m], n);
		end
		ahb(1'b1, HR_MODE, '0, w);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_dir();
		t_fwd();
		t_sense();
		t_back();
		t_fs();
		t_mode();
		final_report();
	end
endmodule // testbench
